/* core/keypad_wake_interrupt.v */
// Eight-channel keypad wake interrupt with an Avalon-MM register slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "keypad_wake_interrupt_map.vh"

// Summary of operation
// - Eight keypad channels, one per port pin, any subset enabled.
// - Enable bit n lets pin n raise its flag and the request.
// - A trigger sets the flag; request only where interrupt is unmasked.
// - All eight channels merge into one interrupt request.
// - Two select bits per channel: fall, rise, either edge, low level.
// - Flag asserts two machine cycles after the trigger on the pin.
// - Edge flags stay set until software clears them by write.
// - Low-level flag follows the inverted pin; writes do not affect it.
// - The request wakes the processor from idle and power-down.
// - Enable, flag and both select registers read zero after reset.
module keypad_wake_interrupt (
   // Clock and reset
   input  wire                     mclk,
   input  wire                     srst,
   // Avalon-MM slave
   input  wire [`BUS_ADDR_W-1:0]   avs_address,
   input  wire                     avs_read,
   input  wire                     avs_write,
   input  wire [`BUS_BE_W-1:0]     avs_byteenable,
   input  wire [`BUS_DATA_W-1:0]   avs_writedata,
   output reg  [`BUS_DATA_W-1:0]   avs_readdata,
   output wire                     avs_waitrequest,
   // Keypad pins
   input  wire [`KEY_CHANNELS-1:0] key_port,
   // Interrupt and wake
   output wire                     keypad_irq,
   output wire                     wake_req
);

   // Configuration registers
   reg  [`KEY_DATA_W-1:0]    key_pin_enable_r;
   reg  [`KEY_DATA_W-1:0]    trigger_select_low_r;
   reg  [`KEY_DATA_W-1:0]    trigger_select_high_r;
   reg  [`KEY_DATA_W-1:0]    irq_mask_r;

   // Bus handshake
   reg                       ack_r;
   reg  [`BUS_DATA_W-1:0]    rdata_nxt;
   wire                      req;
   wire                      wr_take;
   wire                      lane0;
   wire [7:0]                word_idx;
   wire                      aligned;

   // Machine cycle divider
   reg  [`MCYC_CNT_W-1:0]    mc_cnt_r;
   reg  [`MCYC_CNT_W-1:0]    mc_cnt_nxt;
   wire                      mc_en;

   // Channel state
   wire [`KEY_CHANNELS-1:0]  key_pin_flag_bits;
   wire [`KEY_CHANNELS-1:0]  pin_state;
   wire [`KEY_CHANNELS-1:0]  flag_clear;
   wire [`KEY_CHANNELS-1:0]  key_pin_enable_bits;
   wire [`KEY_CHANNELS-1:0]  trig_select_lo;
   wire [`KEY_CHANNELS-1:0]  trig_select_hi;

   assign key_pin_enable_bits = key_pin_enable_r;
   assign trig_select_lo      = trigger_select_low_r;
   assign trig_select_hi      = trigger_select_high_r;

   // Machine cycle tick, one mclk wide
   always @* begin
      if (mc_cnt_r == `MCYC_CLKS - `MCYC_CNT_ONE)
         mc_cnt_nxt = `MCYC_CNT_ZERO;
      else
         mc_cnt_nxt = mc_cnt_r + `MCYC_CNT_ONE;
   end

   always @(posedge mclk) begin
      if (srst)
         mc_cnt_r <= `MCYC_CNT_ZERO;
      else
         mc_cnt_r <= mc_cnt_nxt;
   end

   assign mc_en = (mc_cnt_r == `MCYC_CLKS - `MCYC_CNT_ONE);

   // Bus decode: one wait cycle per access
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_take         = avs_write & ack_r & lane0;
   assign lane0           = avs_byteenable[0];
   assign word_idx        = avs_address[`BUS_ADDR_W-1:`BUS_WORD_LSB];
   assign aligned         = (avs_address[`BUS_WORD_LSB-1:0] == `BUS_LANE_ZERO);

   always @(posedge mclk) begin
      if (srst)
         ack_r <= 1'b0;
      else
         ack_r <= req & ~ack_r;
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      rdata_nxt = `BUS_READ_ZERO;
      if (aligned) begin
         case (word_idx)
            `IDX_PIN_ENABLE:  rdata_nxt = {`BUS_PAD_ZERO, key_pin_enable_r};
            `IDX_PIN_FLAGS:   rdata_nxt = {`BUS_PAD_ZERO, key_pin_flag_bits};
            `IDX_TRIG_SEL_LO: rdata_nxt = {`BUS_PAD_ZERO, trigger_select_low_r};
            `IDX_TRIG_SEL_HI: rdata_nxt = {`BUS_PAD_ZERO, trigger_select_high_r};
            `IDX_IRQ_MASK:    rdata_nxt = {`BUS_PAD_ZERO, irq_mask_r};
            `IDX_PORT_STATE:  rdata_nxt = {`BUS_PAD_ZERO, pin_state};
            default:          rdata_nxt = `BUS_READ_ZERO;
         endcase
      end
   end

   // Read data loaded in the wait cycle, stands in the answer cycle
   always @(posedge mclk) begin
      if (srst)
         avs_readdata <= `BUS_READ_ZERO;
      else if (avs_read && !ack_r)
         avs_readdata <= rdata_nxt;
   end

   always @(posedge mclk) begin
      if (srst) begin
         key_pin_enable_r      <= `RST_PIN_ENABLE;
         trigger_select_low_r  <= `RST_TRIG_SEL_LO;
         trigger_select_high_r <= `RST_TRIG_SEL_HI;
         irq_mask_r            <= `RST_IRQ_MASK;
      end else if (wr_take && aligned) begin
         case (word_idx)
            `IDX_PIN_ENABLE:  key_pin_enable_r      <= avs_writedata[`KEY_DATA_W-1:0];
            `IDX_TRIG_SEL_LO: trigger_select_low_r  <= avs_writedata[`KEY_DATA_W-1:0];
            `IDX_TRIG_SEL_HI: trigger_select_high_r <= avs_writedata[`KEY_DATA_W-1:0];
            `IDX_IRQ_MASK:    irq_mask_r            <= avs_writedata[`KEY_DATA_W-1:0];
            default:          irq_mask_r            <= irq_mask_r;
         endcase
      end
   end

   // write one to clear edge flags
   assign flag_clear = (wr_take && aligned && word_idx == `IDX_PIN_FLAGS) ?
                       avs_writedata[`KEY_DATA_W-1:0] : `RST_PIN_FLAGS;

   genvar ch;
   generate
      for (ch = 0; ch < `KEY_CHANNELS; ch = ch + 1) begin : g_chan
         key_channel u_chan (
            .mclk      (mclk),
            .srst      (srst),
            .mc_en     (mc_en),
            .pin       (key_port[ch]),
            .enable    (key_pin_enable_bits[ch]),
            .sel_hi    (trig_select_hi[ch]),
            .sel_lo    (trig_select_lo[ch]),
            .clear     (flag_clear[ch]),
            .pin_state (pin_state[ch]),
            .flag      (key_pin_flag_bits[ch])
         );
      end
   endgenerate

   assign keypad_irq = |(key_pin_flag_bits & irq_mask_r);

   assign wake_req = keypad_irq;

endmodule // keypad_wake_interrupt

/* inc/keypad_wake_interrupt_map.vh */
// Register map, field codes and timing constants for the keypad wake interrupt block
`ifndef KEYPAD_WAKE_INTERRUPT_MAP_VH
`define KEYPAD_WAKE_INTERRUPT_MAP_VH

// Channel count and data widths
`define KEY_CHANNELS        8
`define KEY_DATA_W          8
`define BUS_DATA_W          32
`define BUS_ADDR_W          10
`define BUS_BE_W            4

// Register indices; byte address is four times the index
`define IDX_PIN_ENABLE      8'he9
`define IDX_PIN_FLAGS       8'hea
`define IDX_TRIG_SEL_LO     8'heb
`define IDX_TRIG_SEL_HI     8'hec
`define IDX_IRQ_MASK        8'hed
`define IDX_PORT_STATE      8'hee

// Register reset values
`define RST_PIN_ENABLE      8'h00
`define RST_PIN_FLAGS       8'h00
`define RST_TRIG_SEL_LO     8'h00
`define RST_TRIG_SEL_HI     8'h00
`define RST_IRQ_MASK        8'h00

// Trigger type codes, high select bit first
`define TRIG_FALL           2'h0
`define TRIG_RISE           2'h1
`define TRIG_BOTH           2'h2
`define TRIG_LOW            2'h3

// Machine cycle length in mclk cycles
`define MCYC_CLKS           4'h4
`define MCYC_CNT_W          4
`define MCYC_CNT_ZERO       4'h0
`define MCYC_CNT_ONE        4'h1

// Bus helpers
`define BUS_WORD_LSB        2
`define BUS_LANE_ZERO       2'h0
`define BUS_READ_ZERO       32'h00000000
`define BUS_PAD_ZERO        24'h000000

`endif

/* core/key_channel.v */
// One keypad channel: pin synchroniser, trigger detection, delay and flag
`timescale 1ns/1ps
`include "keypad_wake_interrupt_map.vh"
module key_channel (
   // Clock and reset
   input  wire mclk,
   input  wire srst,
   // Machine cycle tick
   input  wire mc_en,
   // Pin and configuration
   input  wire pin,
   input  wire enable,
   input  wire sel_hi,
   input  wire sel_lo,
   // Software clear, one-cycle pulse
   input  wire clear,
   // Channel state
   output wire pin_state,
   output wire flag
);

   reg        sync1_r;
   reg        sync2_r;
   reg        cur_r;
   reg        prev_r;
   reg        hit_d1_r;
   reg        low_d1_r;
   reg        flag_r;
   reg        flag_nxt;
   reg        hit;
   wire [1:0] mode;

   assign mode      = {sel_hi, sel_lo};
   assign pin_state = sync2_r;
   assign flag      = flag_r;

   always @(posedge mclk) begin
      if (srst) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= pin;
         sync2_r <= sync1_r;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         cur_r  <= 1'b1;
         prev_r <= 1'b1;
      end else if (mc_en) begin
         cur_r  <= sync2_r;
         prev_r <= cur_r;
      end
   end

   always @* begin
      hit = 1'b0;
      case (mode)
         `TRIG_FALL: hit = prev_r & ~cur_r;
         `TRIG_RISE: hit = ~prev_r & cur_r;
         `TRIG_BOTH: hit = prev_r ^ cur_r;
         default:    hit = 1'b0;
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         hit_d1_r <= 1'b0;
         low_d1_r <= 1'b0;
      end else if (mc_en) begin
         hit_d1_r <= hit;
         low_d1_r <= ~cur_r;
      end
   end

   always @* begin
      flag_nxt = flag_r;
      if (mode == `TRIG_LOW) begin
         if (mc_en)
            flag_nxt = enable & low_d1_r;
      end else begin
         if (clear)
            flag_nxt = 1'b0;
         if (mc_en && enable && hit_d1_r)
            flag_nxt = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (srst)
         flag_r <= 1'b0;
      else
         flag_r <= flag_nxt;
   end

endmodule // key_channel

/* testbench/keypad_wake_interrupt_assertions.sv */
// Bus handshake and interrupt checks for the keypad wake interrupt
`timescale 1ns/1ps
`include "keypad_wake_interrupt_map.vh"
module kwi_checker (
   // Clock and reset
   input wire                    mclk,
   input wire                    srst,
   // Register bus
   input wire [`BUS_ADDR_W-1:0]  avs_address,
   input wire                    avs_read,
   input wire                    avs_write,
   input wire [`BUS_DATA_W-1:0]  avs_readdata,
   input wire                    avs_waitrequest,
   // Interrupt
   input wire                    keypad_irq,
   input wire                    wake_req
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("access without wait cycle");
   a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait longer than one cycle");
   a_wait_bound: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("access never answered");
   a_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait without request");
   a_read_pad: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unaligned_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0)
      else $error("unaligned read not zero");
   a_wake_follows: assert property (wake_req == keypad_irq)
      else $error("wake differs from interrupt");
   a_reset_quiet: assert property ($fell(srst) |-> !keypad_irq && avs_readdata == 32'h0)
      else $error("outputs busy after reset");
   cover property (avs_read && !avs_waitrequest);
   cover property ($rose(keypad_irq));
   cover property ($fell(keypad_irq));
endmodule // kwi_checker
bind keypad_wake_interrupt kwi_checker i_kwi_checker (.mclk, .srst, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .keypad_irq, .wake_req);

/* testbench/key_switches.sv */
// Keypad switch model: pressed keys pull pins low, the pull-up holds the rest high
`timescale 1ns/1ps
module key_switches (
   // Clock
   input  wire       mclk,
   // Pressed keys
   input  wire [7:0] press,
   // Port pins
   output reg  [7:0] key_port
);
   initial key_port = 8'hff;
   always @(posedge mclk) begin
      key_port <= ~press;
   end
endmodule // key_switches

/* testbench/keypad_wake_interrupt_test.sv */
// Self-checking bench for the keypad wake interrupt
`timescale 1ns/1ps
`include "keypad_wake_interrupt_map.vh"
module keypad_wake_interrupt_test;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [9:0]  avs_address = 10'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic [31:0] avs_writedata = 32'h0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire         keypad_irq;
   wire         wake_req;
   wire  [7:0]  key_port;
   logic [7:0]  press = 8'h00;
   logic [7:0]  q;
   int          n_mismatch = 0;
   int          samples_checked = 0;

   always #4 mclk = ~mclk;

   keypad_wake_interrupt i_keypad_wake_interrupt (.mclk, .srst, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .key_port, .keypad_irq, .wake_req);
   key_switches i_key_switches (.mclk, .press, .key_port);

   task final_report;
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
         n_mismatch++;
      end
   endtask

   // Holds the request until waitrequest is seen low
   task bus(input bit w, input logic [9:0] a, input logic [7:0] d, input logic be);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= {3'h0, be};
      n = 0;
      // Waitrequest and read data taken at the same rising edge
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         final_report;
      end
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b1, {i, 2'h0}, d, 1'b1);
   endtask

   task rd(input logic [7:0] i);
      bus(1'b0, {i, 2'h0}, 8'h00, 1'b1);
   endtask

   task settle(input logic [7:0] p);
      @(posedge mclk);
      press <= p;
      repeat (20) @(posedge mclk);
   endtask

   task t_reset;
      int i;
      for (i = 0; i < 5; i++) begin
         rd(`IDX_PIN_ENABLE + i[7:0]);
         chk(q, 8'h00);
      end
      bus(1'b0, 10'h3bd, 8'h00, 1'b1);
      chk(q, 8'h00);
      bus(1'b1, 10'h3a5, 8'hff, 1'b1);
      bus(1'b1, {`IDX_PIN_ENABLE, 2'h0}, 8'h3c, 1'b0);
      rd(`IDX_PIN_ENABLE);
      chk(q, 8'h00);
      wr(`IDX_PIN_ENABLE, 8'h5a);
      rd(`IDX_PIN_ENABLE);
      chk(q, 8'h5a);
   endtask

   // Channels cycle through fall, rise, either, level
   task t_modes;
      wr(`IDX_TRIG_SEL_LO, 8'haa);
      wr(`IDX_TRIG_SEL_HI, 8'hcc);
      wr(`IDX_PIN_ENABLE, 8'hff);
      rd(`IDX_TRIG_SEL_HI);
      chk(q, 8'hcc);
      settle(8'h00);
      wr(`IDX_PIN_FLAGS, 8'hff);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h00);
      settle(8'hff);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'hdd);
      settle(8'h00);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h77);
      wr(`IDX_PIN_FLAGS, 8'hff);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h00);
      settle(8'hff);
      wr(`IDX_PIN_FLAGS, 8'hff);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h88);
      settle(8'h00);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h66);
      wr(`IDX_PIN_FLAGS, 8'hff);
   endtask

   task t_partial;
      wr(`IDX_TRIG_SEL_LO, 8'h00);
      wr(`IDX_TRIG_SEL_HI, 8'h00);
      wr(`IDX_PIN_ENABLE, 8'h0f);
      settle(8'hff);
      rd(`IDX_PIN_FLAGS);
      chk(q, 8'h0f);
      settle(8'h00);
      wr(`IDX_PIN_FLAGS, 8'hff);
   endtask

   task t_irq;
      int n;
      settle(8'h08);
      chk(keypad_irq, 1'b0);
      rd(`IDX_PORT_STATE);
      chk(q, 8'hf7);
      wr(`IDX_IRQ_MASK, 8'h08);
      #1 chk(keypad_irq, 1'b1);
      wr(`IDX_PIN_FLAGS, 8'h08);
      #1 chk(keypad_irq, 1'b0);
      settle(8'h00);
      wr(`IDX_IRQ_MASK, 8'h01);
      @(posedge mclk);
      press <= 8'h01;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (keypad_irq !== 1'b1 && n < 40);
      // Switch flop, two sync flops, wait for tick, then two machine cycles
      chk((n >= 5 + 2 * `MCYC_CLKS) && (n <= 4 + 3 * `MCYC_CLKS), 1'b1);
      chk(wake_req, 1'b1);
      wr(`IDX_PIN_FLAGS, 8'h01);
      #1 chk(wake_req, 1'b0);
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      t_reset;
      t_modes;
      t_partial;
      t_irq;
      final_report;
   end

   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      final_report;
   end
endmodule // keypad_wake_interrupt_test
